/* src/bds_pkg.sv */
// Constants and types shared by the background debug serial controller.
// Assumes a single core clock; the serial link clock is sampled, not used as a clock.
//
// How it works
// - Breakpoint pin low at reset release enables debug until next reset.
// - When enabled, breakpoints, background opcode and double fault enter debug.
// - When disabled: breakpoint pin exception vector 0C, halt on double fault, illegal trap.
// - The software breakpoint opcode never enters debug.
// - Opcode 4AFA is the background entry instruction.
// - No breakpoint acknowledge cycle runs on debug entry.
// - Breakpoint pin is sampled at the data strobe trailing edge.
// - Entry suspends execution, raises freeze first, then enables serial hardware.
// - Entry writes the entry source code into the temporary register.
// - Double fault at initial fetch loads odd value into instruction pointer.
// - Commands are 16-bit words; results shift out during the next word.
// - Fault address tracks each bus cycle in run state and holds the faulting address.
// - Fetching resumes at return PC; odd value gives address error.
// - Instruction pointer holds first word of the last executed instruction.
// - Resume or call command leaves debug, flushes, prefetches from return PC.
// - Freeze drops before the first prefetch; serial pins return to normal.
// - In debug, breakpoint pin is serial clock, fetch pin in, pipe pin out.
// - Full duplex, MSB first, change after falling edge, latch on rising.
// - Serial words are 17 bits, bit 16 status or control.
// - Responses encode valid data, complete, not ready, bus error, illegal; the controller never sends the bus error response.

package bds_pkg;

	// -------------------------------------------------------------------
	// Serial word layout
	// -------------------------------------------------------------------
	localparam int          BDS_WORD_BITS = 17;
	localparam int          BDS_STAT_BIT  = 16;
	localparam logic [4:0]  BDS_CNT_INIT  = 5'h11;
	localparam logic [4:0]  BDS_CNT_LAST  = 5'h01;

	// Response codes, status bit and data
	localparam logic [16:0] BDS_RSP_DONE     = 17'h0FFFF;
	localparam logic [16:0] BDS_RSP_NOTREADY = 17'h10000;
	localparam logic [16:0] BDS_RSP_BUSERR   = 17'h10001;
	localparam logic [16:0] BDS_RSP_ILLEGAL  = 17'h1FFFF;

	// -------------------------------------------------------------------
	// Opcodes and entry codes
	// -------------------------------------------------------------------
	localparam logic [15:0] BDS_OPC_BACKGROUND_ENTRY_OPCODE     = 16'h4AFA;
	localparam logic [15:0] BDS_OPC_SWBK     = 16'h4848;
	localparam logic [15:0] BDS_OPC_SWBK_MSK = 16'hFFF8;
	localparam logic [7:0]  BDS_VEC_BREAKPOINT_REQUEST_PIN     = 8'h0C;
	localparam logic [15:0] BDS_SRC_DBF_LO   = 16'hFFFF;
	localparam logic [31:0] BDS_SRC_BACKGROUND_ENTRY_OPCODE     = 32'h00000001;
	localparam logic [31:0] BDS_SRC_HWBK     = 32'h00000000;
	localparam logic [31:0] BDS_PCC_DBF      = 32'h0FFFFFFF;
	localparam logic [31:0] BDS_ZERO32       = 32'h00000000;

	// -------------------------------------------------------------------
	// Command word: operation field and register select
	// -------------------------------------------------------------------
	localparam int          BDS_OP_HI  = 15;
	localparam int          BDS_OP_LO  = 10;
	localparam logic [5:0]  BDS_OP_NOP = 6'h00;
	localparam logic [5:0]  BDS_OP_RSR = 6'h09;
	localparam logic [5:0]  BDS_OP_WSR = 6'h0A;
	localparam logic [5:0]  BDS_OP_GO  = 6'h03;
	localparam logic [5:0]  BDS_OP_CAL = 6'h02;
	localparam logic [1:0]  BDS_SEL_TMP = 2'h0;
	localparam logic [1:0]  BDS_SEL_FAR = 2'h1;
	localparam logic [1:0]  BDS_SEL_RPC = 2'h2;
	localparam logic [1:0]  BDS_SEL_PCC = 2'h3;

	typedef enum logic [1:0] {BDS_RUN, BDS_DEBUG, BDS_LEAVE, BDS_HALT} bds_state_t;
	typedef enum logic [1:0] {BDS_C_OP, BDS_C_EXT_HI, BDS_C_EXT_LO, BDS_C_RD_LO} bds_cmd_t;

endpackage

/* src/bds_ctrl.sv */
// Background debug controller: debug enable, entry, context registers, serial link.
// Assumes the core supplies decode, bus and pipeline events on core_clk; the
// serial clock and data pins arrive from outside and are synchronised here.

`timescale 1ns/1ps
`default_nettype none

module bds_ctrl
	import bds_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        breakpoint_request_pin,
	input  wire logic        fetch_indication_pin,
	input  wire logic        data_strobe_trail,
	input  wire logic        periph_breakpoint_request_pin,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_opcode,
	input  wire logic [31:0] instr_addr,
	input  wire logic        double_bus_fault,
	input  wire logic        initial_fetch,
	input  wire logic [15:0] special_status_word,
	input  wire logic        bus_cycle_end,
	input  wire logic [31:0] bus_addr,
	input  wire logic        pipe_status_in,
	output logic             freeze,
	output logic             pipeline_status_pin,
	output logic             debug_enabled,
	output logic             breakpoint_request_pin_exception,
	output logic [7:0]       exc_vector,
	output logic             illegal_trap,
	output logic             halted,
	output logic             flush_pipe,
	output logic             prefetch_start,
	output logic [31:0]      prefetch_addr,
	output logic             address_error
);

	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	typedef struct packed {
		bds_state_t  st;
		bds_cmd_t    cmd;
		logic        dbg_en;
		logic        rst_seen;
		logic [1:0]  sel;
		logic [31:0] debug_entry_source_temp;
		logic [31:0] far_r;
		logic [31:0] return_program_counter;
		logic [31:0] current_instruction_pointer;
		logic [16:0] rx;
		logic [16:0] tx;
		logic [4:0]  cnt;
		logic        clk_prev;
		logic        word_rdy;
		logic [15:0] word;
		logic        pipe_out;
		logic        freeze;
		logic        flush;
		logic        prefetch;
		logic        addr_err;
		logic        breakpoint_request_pin_exc;
		logic [7:0]  vec;
		logic        illegal;
		logic        halt;
	} bds_regs_t;

	bds_regs_t q;
	bds_regs_t nxt_q;

	logic sclk_s1_ff;
	logic sclk_s2_ff;
	logic sdi_s1_ff;
	logic sdi_s2_ff;

	// -------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------
	// No reset here so the chain still tracks the pin while reset is held
	always_ff @(posedge core_clk)
	begin
		sclk_s1_ff <= breakpoint_request_pin;
		sclk_s2_ff <= sclk_s1_ff;
		sdi_s1_ff  <= fetch_indication_pin;
		sdi_s2_ff  <= sdi_s1_ff;
	end

	// Decoded events
	logic sclk_rise;
	logic sclk_fall;
	logic ext_breakpoint_request_pin;
	logic background_entry_opcode_op;
	logic swbk_op;
	logic [16:0] rx_next;
	logic [5:0]  op;

	always_comb
	begin
		sclk_rise = q.freeze & sclk_s2_ff & ~q.clk_prev;
		sclk_fall = q.freeze & ~sclk_s2_ff & q.clk_prev;
		ext_breakpoint_request_pin  = data_strobe_trail & ~sclk_s2_ff;
		background_entry_opcode_op   = instr_valid & (instr_opcode == BDS_OPC_BACKGROUND_ENTRY_OPCODE);
		swbk_op   = instr_valid & ((instr_opcode & BDS_OPC_SWBK_MSK) == BDS_OPC_SWBK);
		rx_next   = {q.rx[15:0], sdi_s2_ff};
		op        = q.word[BDS_OP_HI:BDS_OP_LO];
	end

	// Register read mux for the serial read command
	function automatic logic [31:0] sel_reg(input bds_regs_t r, input logic [1:0] s);
		logic [31:0] v;
		v = r.debug_entry_source_temp;
		case (s)
			BDS_SEL_FAR: v = r.far_r;
			BDS_SEL_RPC: v = r.return_program_counter;
			BDS_SEL_PCC: v = r.current_instruction_pointer;
			default:     v = r.debug_entry_source_temp;
		endcase
		return v;
	endfunction

	// -------------------------------------------------------------------
	// Next-state logic
	// -------------------------------------------------------------------
	always_comb
	begin
		logic [31:0] rv;
		rv = sel_reg(q, q.sel);
		nxt_q = q;
		nxt_q.clk_prev = sclk_s2_ff;
		nxt_q.flush    = 1'b0;
		nxt_q.prefetch = 1'b0;
		nxt_q.addr_err = 1'b0;
		nxt_q.breakpoint_request_pin_exc = 1'b0;
		nxt_q.illegal  = 1'b0;
		nxt_q.word_rdy = 1'b0;

		// Latch debug enable once, at the first edge after reset release
		if (!q.rst_seen)
		begin
			nxt_q.rst_seen = 1'b1;
			nxt_q.dbg_en   = ~sclk_s2_ff;
		end

		// Fault address follows every bus cycle in run state, so it holds the faulting one
		if (bus_cycle_end && q.st == BDS_RUN)
		begin
			nxt_q.far_r = bus_addr;
		end

		case (q.st)
			BDS_RUN:
			begin
				nxt_q.pipe_out = pipe_status_in;
				if (instr_valid)
				begin
					nxt_q.current_instruction_pointer = {instr_addr[31:1], 1'b0};
				end
				if (q.dbg_en && (double_bus_fault || ext_breakpoint_request_pin || periph_breakpoint_request_pin || background_entry_opcode_op))
				begin
					// Entry: freeze first, no acknowledge cycle, source recorded
					nxt_q.st     = BDS_DEBUG;
					nxt_q.freeze = 1'b1;
					nxt_q.cnt    = BDS_CNT_INIT;
					nxt_q.cmd    = BDS_C_OP;
					nxt_q.tx     = BDS_RSP_NOTREADY;
					nxt_q.pipe_out = BDS_RSP_NOTREADY[BDS_STAT_BIT];
					if (double_bus_fault)
					begin
						nxt_q.debug_entry_source_temp = {special_status_word, BDS_SRC_DBF_LO};
						nxt_q.current_instruction_pointer   = initial_fetch ? BDS_PCC_DBF : q.current_instruction_pointer;
					end
					else if (ext_breakpoint_request_pin || periph_breakpoint_request_pin)
					begin
						nxt_q.debug_entry_source_temp = BDS_SRC_HWBK;
					end
					else
					begin
						nxt_q.debug_entry_source_temp = BDS_SRC_BACKGROUND_ENTRY_OPCODE;
					end
				end
				else if (!q.dbg_en && double_bus_fault)
				begin
					nxt_q.st   = BDS_HALT;
					nxt_q.halt = 1'b1;
				end
				else if (!q.dbg_en && ext_breakpoint_request_pin)
				begin
					nxt_q.breakpoint_request_pin_exc = 1'b1;
					nxt_q.vec      = BDS_VEC_BREAKPOINT_REQUEST_PIN;
				end
				else if (background_entry_opcode_op || swbk_op)
				begin
					nxt_q.illegal = 1'b1;
				end
			end

			BDS_DEBUG:
			begin
				// Shift in on rising edges; count down the 17 bits
				if (sclk_rise)
				begin
					if (q.cnt == BDS_CNT_LAST)
					begin
						nxt_q.cnt      = BDS_CNT_INIT;
						nxt_q.word     = rx_next[15:0];
						nxt_q.word_rdy = 1'b1;
						nxt_q.tx       = BDS_RSP_NOTREADY;
						nxt_q.pipe_out = BDS_RSP_NOTREADY[BDS_STAT_BIT];
						nxt_q.rx       = rx_next;
					end
					else
					begin
						nxt_q.cnt = q.cnt - BDS_CNT_LAST;
						nxt_q.rx  = rx_next;
					end
				end
				else if (sclk_fall)
				begin
					// Next output bit after the falling edge, MSB first
					nxt_q.pipe_out = q.tx[BDS_STAT_BIT];
					nxt_q.tx       = {q.tx[15:0], 1'b0};
				end

				// Act on each assembled word; result replaces not-ready
				if (q.word_rdy)
				begin
					nxt_q.tx = BDS_RSP_DONE;
					case (q.cmd)
						BDS_C_OP:
						begin
							nxt_q.sel = q.word[1:0];
							if (op == BDS_OP_RSR)
							begin
								rv = sel_reg(q, q.word[1:0]);
								nxt_q.tx  = {1'b0, rv[31:16]};
								nxt_q.cmd = BDS_C_RD_LO;
							end
							else if (op == BDS_OP_WSR && q.word[1:0] == BDS_SEL_RPC)
							begin
								nxt_q.tx  = BDS_RSP_NOTREADY;
								nxt_q.cmd = BDS_C_EXT_HI;
							end
							else if (op == BDS_OP_GO || op == BDS_OP_CAL)
							begin
								nxt_q.st     = BDS_LEAVE;
								nxt_q.freeze = 1'b0;
								nxt_q.flush  = 1'b1;
							end
							else if (op != BDS_OP_NOP)
							begin
								nxt_q.tx = BDS_RSP_ILLEGAL;
							end
						end
						BDS_C_RD_LO:
						begin
							nxt_q.tx  = {1'b0, rv[15:0]};
							nxt_q.cmd = BDS_C_OP;
						end
						BDS_C_EXT_HI:
						begin
							// Temporary register holds the high half meanwhile
							nxt_q.debug_entry_source_temp = {q.word, q.debug_entry_source_temp[15:0]};
							nxt_q.tx    = BDS_RSP_NOTREADY;
							nxt_q.cmd   = BDS_C_EXT_LO;
						end
						BDS_C_EXT_LO:
						begin
							nxt_q.return_program_counter = {q.debug_entry_source_temp[31:16], q.word};
							nxt_q.cmd = BDS_C_OP;
						end
						default: nxt_q.cmd = BDS_C_OP;
					endcase
					nxt_q.pipe_out = nxt_q.tx[BDS_STAT_BIT];
				end
			end

			BDS_LEAVE:
			begin
				// Freeze already low; prefetch from return PC now
				nxt_q.st       = BDS_RUN;
				nxt_q.prefetch = 1'b1;
				nxt_q.addr_err = q.return_program_counter[0];
				nxt_q.pipe_out = pipe_status_in;
			end

			BDS_HALT:
			begin
				nxt_q.st = BDS_HALT;
			end

			default: nxt_q.st = BDS_RUN;
		endcase
	end

	// -------------------------------------------------------------------
	// State register
	// -------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q          <= '0;
			q.st       <= BDS_RUN;
			q.cmd      <= BDS_C_OP;
			q.cnt      <= BDS_CNT_INIT;
			q.clk_prev <= 1'b1;
		end
		else
		begin
			q <= nxt_q;
		end
	end

	// Outputs straight from the state flops
	assign freeze              = q.freeze;
	assign pipeline_status_pin = q.pipe_out;
	assign debug_enabled       = q.dbg_en;
	assign breakpoint_request_pin_exception      = q.breakpoint_request_pin_exc;
	assign exc_vector          = q.vec;
	assign illegal_trap        = q.illegal;
	assign halted              = q.halt;
	assign flush_pipe          = q.flush;
	assign prefetch_start      = q.prefetch;
	assign prefetch_addr       = q.return_program_counter;
	assign address_error       = q.addr_err;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_enable_latch: assert property (!q.rst_seen |=> q.dbg_en == !$past(sclk_s2_ff))
		else $error("debug enable not taken from pin");
	a_entry_freeze: assert property ((q.st == BDS_RUN && q.dbg_en && double_bus_fault)
		|=> q.freeze && q.debug_entry_source_temp[15:0] == BDS_SRC_DBF_LO)
		else $error("double fault did not enter debug");
	a_disabled_exc: assert property ((q.st == BDS_RUN && !q.dbg_en && ext_breakpoint_request_pin && !double_bus_fault)
		|=> breakpoint_request_pin_exception && exc_vector == BDS_VEC_BREAKPOINT_REQUEST_PIN && !q.freeze)
		else $error("disabled breakpoint not an exception");
	a_swbk_no_entry: assert property ((q.st == BDS_RUN && swbk_op && !ext_breakpoint_request_pin && !periph_breakpoint_request_pin
		&& !double_bus_fault) |=> !q.freeze && illegal_trap)
		else $error("software breakpoint entered debug");
	a_background_entry_opcode_source: assert property ((q.st == BDS_RUN && q.dbg_en && background_entry_opcode_op && !ext_breakpoint_request_pin
		&& !periph_breakpoint_request_pin && !double_bus_fault) |=> q.debug_entry_source_temp == BDS_SRC_BACKGROUND_ENTRY_OPCODE)
		else $error("background entry code wrong");
	a_pcc_odd: assert property (q.current_instruction_pointer[0] && !$past(q.current_instruction_pointer[0]) |-> q.current_instruction_pointer == BDS_PCC_DBF)
		else $error("odd instruction pointer outside double fault");
	a_word_notready: assert property ((sclk_rise && q.cnt == BDS_CNT_LAST)
		|=> pipeline_status_pin ##1 q.tx != BDS_RSP_NOTREADY || q.cmd != BDS_C_OP)
		else $error("word end did not show not ready");
	a_exit_order: assert property ($rose(flush_pipe) |-> !freeze ##1 prefetch_start && !freeze
		&& address_error == q.return_program_counter[0])
		else $error("exit order wrong");
	a_quiet_run: assert property (!q.freeze |-> q.cnt == BDS_CNT_INIT || $past(q.freeze))
		else $error("serial counter moved outside debug");

	c_background_entry_opcode_entry: cover property (q.st == BDS_RUN && q.dbg_en && background_entry_opcode_op ##1 q.freeze);
	c_read_reg:   cover property (q.word_rdy && q.cmd == BDS_C_OP && op == BDS_OP_RSR);
	c_illegal:    cover property (q.tx == BDS_RSP_ILLEGAL);
	c_exit:       cover property (flush_pipe ##1 prefetch_start);

endmodule

`default_nettype wire

/* verif/bds_host_model.sv */
// Development system model: makes the serial clock, drives data in, samples data out.
// Assumes the bench calls its tasks; the clock pin doubles as breakpoint request in run.

`timescale 1ns/1ps
`default_nettype none

module bds_host_model
(
	output logic      debug_serial_clock,
	output logic      dsi,
	input  wire logic debug_serial_out
);
	// -------------------------------------------------------------------
	// Link timing
	// -------------------------------------------------------------------
	localparam int HALF = 400;	// 800 ns period, below half the core clock

	// Idle levels: clock high between words
	initial
	begin
		debug_serial_clock = 1'b1;
		dsi   = 1'b0;
	end

	// Breakpoint request level while the core runs
	task automatic set_pin(input logic v);
		debug_serial_clock <= v;
	endtask

	// One 17-bit word, MSB first, both directions at once
	task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
		#1037;
		for (int i = 16; i >= 0; i--)
		begin
			debug_serial_clock <= 1'b0;
			#50 dsi <= tx[i];	// Change after the falling edge
			#(HALF - 50) debug_serial_clock <= 1'b1;
			#150 rx[i] = debug_serial_out;	// Output lags behind the core synchronisers
			#(HALF - 150);
		end
		dsi <= ~dsi;	// Released line shows no stale bit
	endtask
endmodule

`default_nettype wire

/* verif/background_debug_serial_bench.sv */
// Self-checking bench for the debug controller with a reference model of the link.
// Assumes bds_pkg, bds_ctrl and bds_host_model are compiled first.

`timescale 1ns/1ps
`default_nettype none

module background_debug_serial_bench;
	import bds_pkg::*;

	// -------------------------------------------------------------------
	// Signals and model state
	// -------------------------------------------------------------------
	localparam int LIMIT = 20000;
	logic core_clk, nrst, data_strobe_trail, periph_breakpoint_request_pin, instr_valid;
	logic double_bus_fault, initial_fetch, bus_cycle_end, pipe_status_in;
	logic [15:0] instr_opcode, special_status_word;
	logic [31:0] instr_addr, bus_addr, rnd, m_tmp, m_far, m_rpc, m_pcc;
	wire logic debug_serial_clock, dsi, debug_serial_out;
	logic freeze, debug_enabled, breakpoint_request_pin_exception, illegal_trap, halted;
	logic flush_pipe, prefetch_start, address_error;
	logic [7:0] exc_vector;
	logic [31:0] prefetch_addr;
	logic [16:0] pend[$];
	int num_errors = 0, check_count = 0, cyc = 0, skip = 0, seed = 61;
	bit wr;

	bds_ctrl uut (.core_clk(core_clk), .nrst(nrst), .breakpoint_request_pin(debug_serial_clock),
		.fetch_indication_pin(dsi), .data_strobe_trail(data_strobe_trail),
		.periph_breakpoint_request_pin(periph_breakpoint_request_pin), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
		.instr_addr(instr_addr), .double_bus_fault(double_bus_fault),
		.initial_fetch(initial_fetch), .special_status_word(special_status_word),
		.bus_cycle_end(bus_cycle_end), .bus_addr(bus_addr), .pipe_status_in(pipe_status_in),
		.freeze(freeze), .pipeline_status_pin(debug_serial_out), .debug_enabled(debug_enabled),
		.breakpoint_request_pin_exception(breakpoint_request_pin_exception), .exc_vector(exc_vector), .illegal_trap(illegal_trap),
		.halted(halted), .flush_pipe(flush_pipe), .prefetch_start(prefetch_start),
		.prefetch_addr(prefetch_addr), .address_error(address_error));

	bds_host_model host (.debug_serial_clock(debug_serial_clock), .dsi(dsi), .debug_serial_out(debug_serial_out));

	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		pipe_status_in <= rnd[cyc % 32];
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			num_errors++;
			$display("BAD t=%0t run did not finish", $time);
			conclude();
		end
	end

	// -------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic do_reset(input logic pin);
		@(posedge core_clk);
		nrst <= 1'b0;
		host.set_pin(pin);	// Pin settles through the synchroniser
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge core_clk);
		host.set_pin(1'b1);
		#1;
	endtask

	// One-cycle core event; outputs checked right after the taking edge
	task automatic ev(input int k);
		pend.delete();
		skip = 0;
		@(posedge core_clk);
		case (k)
			0: data_strobe_trail <= 1'b1;
			1: periph_breakpoint_request_pin <= 1'b1;
			2: instr_valid <= 1'b1;
			3: double_bus_fault <= 1'b1;
			default: bus_cycle_end <= 1'b1;
		endcase
		@(posedge core_clk);
		{data_strobe_trail, periph_breakpoint_request_pin, instr_valid, double_bus_fault, bus_cycle_end} <= 5'h00;
		#1;
	endtask

	// Word exchange plus reference model of replies, one word behind
	task automatic send(input logic [16:0] w);
		logic [16:0] rx;
		logic [31:0] v;
		host.xfer(w, rx);
		if (pend.size() > 0)
			chk({15'h0000, rx}, {15'h0000, pend.pop_front()}, "reply");
		v = (w[1:0] == BDS_SEL_TMP) ? m_tmp : (w[1:0] == BDS_SEL_FAR) ? m_far :
			(w[1:0] == BDS_SEL_RPC) ? m_rpc : m_pcc;
		if (skip > 0)
		begin
			if (wr && skip == 2)
				m_rpc[31:16] = w[15:0];
			else if (wr)
				m_rpc[15:0] = w[15:0];
			skip--;
		end
		else if (w[15:10] == BDS_OP_NOP)
			pend.push_back(BDS_RSP_DONE);
		else if (w[15:10] == BDS_OP_RSR)
		begin
			pend.push_back({1'b0, v[31:16]});
			pend.push_back({1'b0, v[15:0]});
			skip = 1;
			wr = 0;
		end
		else if (w[15:10] == BDS_OP_WSR)
		begin
			pend.push_back(BDS_RSP_NOTREADY);
			pend.push_back(BDS_RSP_NOTREADY);
			pend.push_back(BDS_RSP_DONE);
			skip = 2;
			wr = 1;
		end
		else if (w[15:10] != BDS_OP_GO && w[15:10] != BDS_OP_CAL)
			pend.push_back(BDS_RSP_ILLEGAL);
	endtask

	task automatic rd(input logic [1:0] sel);
		send({1'b0, BDS_OP_RSR, 8'h00, sel});	// Control bit sent clear
		send(17'h00000);
		send(17'h00000);
	endtask

	task automatic wrpc(input logic [31:0] v);
		send({1'b0, BDS_OP_WSR, 8'h00, BDS_SEL_RPC});
		send({1'b0, v[31:16]});
		send({1'b0, v[15:0]});
	endtask

	task automatic leave(input logic [5:0] op);
		int n;
		send({1'b0, op, 10'h000});
		n = 0;
		while (flush_pipe !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(flush_pipe, 1, "flush");
		chk(freeze, 0, "freeze at flush");
		@(posedge core_clk);
		#1;
		chk(prefetch_start, 1, "prefetch");
		chk(prefetch_addr, m_rpc, "prefetch addr");
		chk(address_error, m_rpc[0], "odd resume");
	endtask

	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial
	begin
		{data_strobe_trail, periph_breakpoint_request_pin, instr_valid, double_bus_fault} = 4'h0;
		{initial_fetch, bus_cycle_end, pipe_status_in, nrst} = 4'h0;
		{instr_opcode, special_status_word} = 32'h00000000;
		{instr_addr, bus_addr, rnd} = 96'h0;
		do_reset(1'b1);
		chk(debug_enabled, 0, "enable high pin");
		host.set_pin(1'b0);
		repeat (3) @(posedge core_clk);
		ev(0);
		host.set_pin(1'b1);
		chk({breakpoint_request_pin_exception, freeze}, 2'h2, "ext break off");
		chk(exc_vector, BDS_VEC_BREAKPOINT_REQUEST_PIN, "vector");
		for (int k = 0; k < 2; k++)
		begin
			rnd = $random(seed);
			instr_opcode <= k ? (BDS_OPC_SWBK | {13'h0000, rnd[2:0]}) : BDS_OPC_BACKGROUND_ENTRY_OPCODE;
			ev(2);
			chk({illegal_trap, freeze}, 2'h2, "opcode off");
		end
		ev(3);
		chk({halted, freeze}, 2'h2, "double fault off");
		do_reset(1'b0);
		chk({debug_enabled, halted}, 2'h2, "enable low pin");
		instr_opcode <= BDS_OPC_SWBK | 16'h0007;
		ev(2);
		chk({illegal_trap, freeze}, 2'h2, "sw break on");
		rnd = $random(seed);
		bus_addr <= rnd;
		m_far = rnd;
		ev(4);
		instr_opcode <= BDS_OPC_BACKGROUND_ENTRY_OPCODE;
		instr_addr <= (rnd ^ 32'h00FF00FE) & 32'hFFFFFFFE;
		m_pcc = (rnd ^ 32'h00FF00FE) & 32'hFFFFFFFE;
		m_tmp = BDS_SRC_BACKGROUND_ENTRY_OPCODE;
		ev(2);
		chk({freeze, breakpoint_request_pin_exception, illegal_trap}, 3'h4, "background_entry_opcode entry");
		rd(BDS_SEL_TMP);
		rd(BDS_SEL_FAR);
		rd(BDS_SEL_PCC);
		wrpc($random(seed) | 1);
		send({1'b0, 6'h3F, 10'h000});
		leave(BDS_OP_GO);
		m_tmp = BDS_SRC_HWBK;
		ev(1);
		chk(freeze, 1, "periph entry");
		rd(BDS_SEL_TMP);
		wrpc($random(seed) & 32'hFFFFFFFE);
		leave(BDS_OP_CAL);
		rnd = $random(seed);
		special_status_word <= rnd[15:0];
		initial_fetch <= 1'b1;
		m_tmp = {rnd[15:0], BDS_SRC_DBF_LO};
		m_pcc = BDS_PCC_DBF;
		ev(3);
		initial_fetch <= 1'b0;
		chk({freeze, halted}, 2'h2, "double fault on");
		rd(BDS_SEL_TMP);
		rd(BDS_SEL_PCC);
		leave(BDS_OP_GO);
		conclude();
	end
endmodule

`default_nettype wire
